/* hw/jtag_tap_boundary_scan.sv */
// Test access port with instruction decode, boundary-scan chain and flash access registers.
//
// Functional notes
// - A 16-bit instruction register, shifted through the port, decodes eight instructions.
// - Code 0x0000 selects the boundary chain in external-test mode, pins under tester.
// - Code 0x0002 selects the boundary chain for sampling pins and presetting latches.
// - Code 0x0004 selects the 32-bit identification register.
// - Code 0xFFFF selects the single-stage bypass register between data in and out.
// - Code 0x0082 selects the flash control register.
// - Code 0x0083 selects the flash data register.
// - Code 0x0084 selects the flash address register.
// - Code 0x0085 selects the flash timing scale register.
// - The boundary chain is 134 bits covering pins, bus and pull-up control.
// - External test captures and updates pins; sample mode captures and fills the update latches but never drives pins.
// - During external test every input to on-chip logic is forced high.
// - Small package: bit 0 is reset-pin enable, bit 1 reset-pin data.
// - Large package: bit 2 is reset-pin enable, bit 3 reset-pin data.
// - Bit 4 captures the crystal input pin; its update drives nothing.
// - Bit 5 captures core pull-up enable and updates the pins' pull-up enable.
// - Even bit of each pin pair is output enable, port 0 pin 0 at bit 6.
// - Odd bit of each pin pair is pin input and output, starting at bit 7.
// - Ports 0 to 7 take 16 bits each; port 7 ends at bit 133.
// - Three boundary-scan data registers plus four flash access registers exist.
`default_nettype none
module jtag_tap_boundary_scan #(
    parameter bit LARGE_PACKAGE = 1'b1,
    // Identification value is arbitrary; bit 0 stays high as the standard requires.
    parameter logic [31:0] ID_CODE = 32'h0a5a_5001
) (
    // System clock and reset
    input wire logic clk,
    input wire logic rst,
    // Test access port
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_en_n,
    // Port pins
    input wire logic [63:0] pin_in,
    output logic [63:0] pin_out,
    output logic [63:0] pin_oe_n,
    // Reset pin and other pins
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe_n,
    input wire logic crystal_input_pin,
    output logic pullup_en,
    // Core side
    input wire logic [63:0] core_out,
    input wire logic [63:0] core_oe,
    output logic [63:0] core_in,
    input wire logic core_rst_drive,
    input wire logic core_rst_out,
    output logic core_rst_in,
    input wire logic core_pullup_en,
    // Flash access registers
    output logic [7:0] flash_control_reg,
    output logic [9:0] flash_data_reg,
    output logic [16:0] flash_address_reg,
    output logic [7:0] flash_timing_scale_reg
);
    import jtag_tap_pkg::*;

    localparam int NPIN = `NUM_PORTS * `PINS_PER_PORT;
    localparam int CW = `CHAIN_W;
    localparam int SW = 2 * NPIN + 4;
    localparam int RST_EN_BIT = LARGE_PACKAGE ? `LARGE_RST_EN_BIT : `SMALL_RST_EN_BIT;
    localparam int RST_IO_BIT = LARGE_PACKAGE ? `LARGE_RST_IO_BIT : `SMALL_RST_IO_BIT;

    tap_state_t state;
    data_sel_t sel;
    logic [`INSTR_W-1:0] instr;
    logic [`INSTR_W-1:0] instr_shift;
    logic [CW-1:0] bsr_shift;
    logic [CW-1:0] bsr_upd;
    logic [CW-1:0] cap_vec;
    logic [`ID_W-1:0] id_shift;
    logic byp;
    logic [`FLASH_SHIFT_W-1:0] flash_shift;
    logic [`FLASH_SHIFT_W-1:0] flash_cap;
    logic [SW-1:0] cap_meta;
    logic [SW-1:0] cap_sync;
    logic [NPIN-1:0] s_pin;
    logic [NPIN-1:0] s_oe;
    logic s_rst_en;
    logic s_rst_pin;
    logic s_xtal;
    logic s_pull;
    logic upd_toggle;
    logic extest_t;
    logic ext_meta;
    logic ext_sync;
    logic tog_meta;
    logic tog_sync;
    logic tog_seen;
    logic [CW-1:0] upd_clk;
    logic [NPIN:0] in_meta;
    logic [NPIN:0] in_sync;
    logic [NPIN-1:0] next_pin_out;
    logic [NPIN-1:0] next_pin_oe_n;

    tap_fsm u_tap_fsm (
        .tck(tck),
        .rst(rst),
        .tms(tms),
        .state(state)
    );

    ////////////////////////////////////////////////////////////////////////////////////////
    // Instruction register and decode.

    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            instr_shift <= `INSTR_RESET;
            instr <= `INSTR_RESET;
        end else if (state == ST_TLR) begin
            instr_shift <= `INSTR_RESET;
            instr <= `INSTR_RESET;
        end else if (state == ST_CAP_INSTR) begin
            instr_shift <= `INSTR_CAPTURE;
        end else if (state == ST_SH_INSTR) begin
            instr_shift <= {tdi, instr_shift[`INSTR_W-1:1]};
        end else if (state == ST_UPD_INSTR) begin
            instr <= instr_shift;
        end
    end

    always_comb begin
        case (instr)
            `EXTEST_CODE: sel = SEL_BOUNDARY;
            `INSTR_A_CODE: sel = SEL_BOUNDARY;
            `IDCODE_CODE: sel = SEL_ID;
            `FLASH_CTL_CODE: sel = SEL_FLASH;
            `FLASH_DAT_CODE: sel = SEL_FLASH;
            `FLASH_ADR_CODE: sel = SEL_FLASH;
            `FLASH_SCL_CODE: sel = SEL_FLASH;
            default: sel = SEL_BYPASS;
        endcase
    end

    assign extest_t = (instr == `EXTEST_CODE);

    ////////////////////////////////////////////////////////////////////////////////////////
    // Capture side: pins and core levels are asynchronous to the test clock.

    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            cap_meta <= '0;
            cap_sync <= '0;
        end else begin
            cap_meta <= {pin_in, core_oe, core_rst_drive, rst_pin_in, crystal_input_pin,
                         core_pullup_en};
            cap_sync <= cap_meta;
        end
    end

    assign s_pin = cap_sync[SW-1 -: NPIN];
    assign s_oe = cap_sync[NPIN+3 -: NPIN];
    assign s_rst_en = cap_sync[3];
    assign s_rst_pin = cap_sync[2];
    assign s_xtal = cap_sync[1];
    assign s_pull = cap_sync[0];

    // The reset bits of the absent package capture zero.
    assign cap_vec[`SMALL_RST_EN_BIT] = LARGE_PACKAGE ? 1'b0 : s_rst_en;
    assign cap_vec[`SMALL_RST_IO_BIT] = LARGE_PACKAGE ? 1'b0 : s_rst_pin;
    assign cap_vec[`LARGE_RST_EN_BIT] = LARGE_PACKAGE ? s_rst_en : 1'b0;
    assign cap_vec[`LARGE_RST_IO_BIT] = LARGE_PACKAGE ? s_rst_pin : 1'b0;
    assign cap_vec[`CLK_IN_BIT] = s_xtal;
    assign cap_vec[`PULLUP_BIT] = s_pull;

    // Pin i of port p sits at bit 6 + 16p + 2n, which is 6 + 2i.
    for (genvar i = 0; i < NPIN; i++) begin : g_cap
        assign cap_vec[`PORT_BASE_BIT + 2*i] = s_oe[i];
        assign cap_vec[`PORT_BASE_BIT + 2*i + 1] = s_pin[i];
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Data registers, each shifting least significant bit first.

    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            bsr_shift <= '0;
        end else if (sel == SEL_BOUNDARY && state == ST_CAP_DATA) begin
            bsr_shift <= cap_vec;
        end else if (sel == SEL_BOUNDARY && state == ST_SH_DATA) begin
            bsr_shift <= {tdi, bsr_shift[CW-1:1]};
        end
    end

    // Preload fills the latches in both modes; only external test lets them reach the pins.
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            bsr_upd <= '0;
            upd_toggle <= 1'b0;
        end else if (sel == SEL_BOUNDARY && state == ST_UPD_DATA) begin
            bsr_upd <= bsr_shift;
            upd_toggle <= ~upd_toggle;
        end
    end

    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            id_shift <= '0;
        end else if (sel == SEL_ID && state == ST_CAP_DATA) begin
            id_shift <= ID_CODE;
        end else if (sel == SEL_ID && state == ST_SH_DATA) begin
            id_shift <= {tdi, id_shift[`ID_W-1:1]};
        end
    end

    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            byp <= 1'b0;
        end else if (sel == SEL_BYPASS && state == ST_CAP_DATA) begin
            byp <= 1'b0;
        end else if (sel == SEL_BYPASS && state == ST_SH_DATA) begin
            byp <= tdi;
        end
    end

    always_comb begin
        flash_cap = '0;
        case (instr)
            `FLASH_CTL_CODE: flash_cap[`FLASH_CTL_W-1:0] = flash_control_reg;
            `FLASH_DAT_CODE: flash_cap[`FLASH_DAT_W-1:0] = flash_data_reg;
            `FLASH_ADR_CODE: flash_cap[`FLASH_ADR_W-1:0] = flash_address_reg;
            `FLASH_SCL_CODE: flash_cap[`FLASH_SCL_W-1:0] = flash_timing_scale_reg;
            default: flash_cap = '0;
        endcase
    end

    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            flash_shift <= '0;
        end else if (sel == SEL_FLASH && state == ST_CAP_DATA) begin
            flash_shift <= flash_cap;
        end else if (sel == SEL_FLASH && state == ST_SH_DATA) begin
            flash_shift <= {tdi, flash_shift[`FLASH_SHIFT_W-1:1]};
        end
    end

    // A full 20-bit scan leaves the new value in the low bits of the shift stage.
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            flash_control_reg <= `FLASH_CTL_RESET;
            flash_data_reg <= `FLASH_DAT_RESET;
            flash_address_reg <= `FLASH_ADR_RESET;
            flash_timing_scale_reg <= `FLASH_SCL_RESET;
        end else if (state == ST_UPD_DATA) begin
            case (instr)
                `FLASH_CTL_CODE: flash_control_reg <= flash_shift[`FLASH_CTL_W-1:0];
                `FLASH_DAT_CODE: flash_data_reg <= flash_shift[`FLASH_DAT_W-1:0];
                `FLASH_ADR_CODE: flash_address_reg <= flash_shift[`FLASH_ADR_W-1:0];
                `FLASH_SCL_CODE: flash_timing_scale_reg <= flash_shift[`FLASH_SCL_W-1:0];
                default: flash_control_reg <= flash_control_reg;
            endcase
        end
    end

    // Data out changes on the falling edge so the tester samples it half a period later.
    always_ff @(negedge tck or posedge rst) begin
        if (rst) begin
            tdo <= 1'b0;
            tdo_en_n <= 1'b1;
        end else begin
            tdo_en_n <= !(state == ST_SH_DATA || state == ST_SH_INSTR);
            if (state == ST_SH_INSTR) begin
                tdo <= instr_shift[0];
            end else begin
                case (sel)
                    SEL_BOUNDARY: tdo <= bsr_shift[0];
                    SEL_ID: tdo <= id_shift[0];
                    SEL_FLASH: tdo <= flash_shift[0];
                    default: tdo <= byp;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // System-clock side: mode level, update latches by toggle handshake, pin drivers.

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            tog_meta <= 1'b0;
            tog_sync <= 1'b0;
            tog_seen <= 1'b0;
        end else begin
            ext_meta <= extest_t;
            ext_sync <= ext_meta;
            tog_meta <= upd_toggle;
            tog_sync <= tog_meta;
            tog_seen <= tog_sync;
        end
    end

    // The update latches only change at an update, long before the next toggle arrives.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            upd_clk <= '0;
        end else if (tog_sync != tog_seen) begin
            upd_clk <= bsr_upd;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in_meta <= '0;
            in_sync <= '0;
        end else begin
            in_meta <= {pin_in, rst_pin_in};
            in_sync <= in_meta;
        end
    end

    for (genvar i = 0; i < NPIN; i++) begin : g_drv
        assign next_pin_out[i] = ext_sync ? upd_clk[`PORT_BASE_BIT + 2*i + 1] : core_out[i];
        assign next_pin_oe_n[i] = ext_sync ? ~upd_clk[`PORT_BASE_BIT + 2*i] : ~core_oe[i];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_out <= '0;
            pin_oe_n <= '1;
            rst_pin_out <= 1'b0;
            rst_pin_oe_n <= 1'b1;
            pullup_en <= 1'b0;
            core_in <= '1;
            core_rst_in <= 1'b1;
        end else begin
            pin_out <= next_pin_out;
            pin_oe_n <= next_pin_oe_n;
            rst_pin_out <= ext_sync ? upd_clk[RST_IO_BIT] : core_rst_out;
            rst_pin_oe_n <= ext_sync ? ~upd_clk[RST_EN_BIT] : ~core_rst_drive;
            pullup_en <= ext_sync ? upd_clk[`PULLUP_BIT] : core_pullup_en;
            core_in <= ext_sync ? '1 : in_sync[NPIN:1];
            core_rst_in <= ext_sync ? 1'b1 : in_sync[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_boundary_update;
        (state == ST_UPD_DATA) && (sel == SEL_BOUNDARY);
    endsequence

    sequence s_load_instr;
        (state == ST_UPD_INSTR) ##1 (state != ST_TLR);
    endsequence

    a_instr_reset_value: assert property (@(posedge tck) disable iff (rst)
        (state == ST_TLR) |=> (instr == 16'h0000))
        else $error("instruction register did not take its reset value");

    a_instr_shift_path: assert property (@(posedge tck) disable iff (rst)
        (state == ST_SH_INSTR) |=> (instr_shift[15] == $past(tdi)))
        else $error("instruction shift stage lost the serial input");

    a_instr_load: assert property (@(posedge tck) disable iff (rst)
        s_load_instr |-> (instr == $past(instr_shift, 1)))
        else $error("instruction not taken at update");

    a_unknown_bypass: assert property (@(posedge tck) disable iff (rst)
        (instr == 16'h0001 || instr == 16'hffff) |-> (sel == SEL_BYPASS))
        else $error("undefined code did not select bypass");

    a_bypass_capture: assert property (@(posedge tck) disable iff (rst)
        (state == ST_CAP_DATA && sel == SEL_BYPASS) |=> (byp == 1'b0))
        else $error("bypass stage did not capture zero");

    a_idcode_capture: assert property (@(posedge tck) disable iff (rst)
        (state == ST_CAP_DATA && instr == 16'h0004) |=> (id_shift == ID_CODE))
        else $error("identification value not captured");

    a_chain_shift: assert property (@(posedge tck) disable iff (rst)
        (state == ST_SH_DATA && sel == SEL_BOUNDARY)
        |=> (bsr_shift[133] == $past(tdi)) && (bsr_shift[0] == $past(bsr_shift[1])))
        else $error("boundary chain shift is not 134 bits long");

    a_chain_update: assert property (@(posedge tck) disable iff (rst)
        s_boundary_update |=> (bsr_upd == $past(bsr_shift)))
        else $error("boundary update latches not loaded");

    a_flash_ctl_load: assert property (@(posedge tck) disable iff (rst)
        (state == ST_UPD_DATA && instr == 16'h0082)
        |=> (flash_control_reg == $past(flash_shift[7:0])))
        else $error("flash control register not loaded");

    a_extest_force: assert property (@(posedge clk) disable iff (rst)
        ext_sync |=> (core_in == '1) && core_rst_in)
        else $error("core inputs not forced high in external test");

    a_sample_core_drive: assert property (@(posedge clk) disable iff (rst)
        !ext_sync |=> (pin_out == $past(core_out)) && (pin_oe_n == ~$past(core_oe)))
        else $error("pins not driven by the core outside external test");

    a_pin_map: assert property (@(posedge clk) disable iff (rst)
        ext_sync |=> (pin_out[0] == $past(upd_clk[7])) && (pin_oe_n[63] == ~$past(upd_clk[132]))
        && (pin_out[63] == $past(upd_clk[133])))
        else $error("pin pair mapping of the boundary chain is wrong");
endmodule : jtag_tap_boundary_scan
`default_nettype wire

/* hw/jtag_tap_map.svh */
// Constants for the test access port: instruction codes, chain layout and register widths.
`ifndef JTAG_TAP_MAP_SVH
`define JTAG_TAP_MAP_SVH

`define INSTR_W 16
`define INSTR_RESET 16'h0000
`define INSTR_CAPTURE 16'h0001

`define EXTEST_CODE 16'h0000
`define INSTR_A_CODE 16'h0002
`define IDCODE_CODE 16'h0004
`define BYPASS_CODE 16'hffff
`define FLASH_CTL_CODE 16'h0082
`define FLASH_DAT_CODE 16'h0083
`define FLASH_ADR_CODE 16'h0084
`define FLASH_SCL_CODE 16'h0085

`define CHAIN_W 134
`define ID_W 32
`define SMALL_RST_EN_BIT 0
`define SMALL_RST_IO_BIT 1
`define LARGE_RST_EN_BIT 2
`define LARGE_RST_IO_BIT 3
`define CLK_IN_BIT 4
`define PULLUP_BIT 5
`define PORT_BASE_BIT 6
`define PORT_BITS 16
`define NUM_PORTS 8
`define PINS_PER_PORT 8

`define FLASH_SHIFT_W 20
`define FLASH_CTL_W 8
`define FLASH_DAT_W 10
`define FLASH_ADR_W 17
`define FLASH_SCL_W 8
`define FLASH_CTL_RESET 8'h00
`define FLASH_DAT_RESET 10'h000
`define FLASH_ADR_RESET 17'h00000
`define FLASH_SCL_RESET 8'h00

`endif

/* hw/jtag_tap_pkg.sv */
// Types shared by the test access port controller and the boundary-scan block.
`default_nettype none
package jtag_tap_pkg;
    `include "jtag_tap_map.svh"

    typedef enum logic [15:0] {
        ST_TLR = 16'h0001,
        ST_IDLE = 16'h0002,
        ST_SEL_DATA = 16'h0004,
        ST_CAP_DATA = 16'h0008,
        ST_SH_DATA = 16'h0010,
        ST_EX1_DATA = 16'h0020,
        ST_PAUSE_DATA = 16'h0040,
        ST_EX2_DATA = 16'h0080,
        ST_UPD_DATA = 16'h0100,
        ST_SEL_INSTR = 16'h0200,
        ST_CAP_INSTR = 16'h0400,
        ST_SH_INSTR = 16'h0800,
        ST_EX1_INSTR = 16'h1000,
        ST_PAUSE_INSTR = 16'h2000,
        ST_EX2_INSTR = 16'h4000,
        ST_UPD_INSTR = 16'h8000
    } tap_state_t;

    typedef enum logic [3:0] {
        SEL_BOUNDARY = 4'h1,
        SEL_ID = 4'h2,
        SEL_BYPASS = 4'h4,
        SEL_FLASH = 4'h8
    } data_sel_t;
endpackage : jtag_tap_pkg
`default_nettype wire

/* hw/tap_fsm.sv */
// Sixteen-state test access port controller clocked by the test clock.
`default_nettype none
module tap_fsm (
    // Test clock and reset
    input wire logic tck,
    input wire logic rst,
    // Mode select
    input wire logic tms,
    // Controller state
    output var jtag_tap_pkg::tap_state_t state
);
    import jtag_tap_pkg::*;

    tap_state_t next_state;

    always_comb begin
        case (state)
            ST_TLR: next_state = tms ? ST_TLR : ST_IDLE;
            ST_IDLE: next_state = tms ? ST_SEL_DATA : ST_IDLE;
            ST_SEL_DATA: next_state = tms ? ST_SEL_INSTR : ST_CAP_DATA;
            ST_CAP_DATA: next_state = tms ? ST_EX1_DATA : ST_SH_DATA;
            ST_SH_DATA: next_state = tms ? ST_EX1_DATA : ST_SH_DATA;
            ST_EX1_DATA: next_state = tms ? ST_UPD_DATA : ST_PAUSE_DATA;
            ST_PAUSE_DATA: next_state = tms ? ST_EX2_DATA : ST_PAUSE_DATA;
            ST_EX2_DATA: next_state = tms ? ST_UPD_DATA : ST_SH_DATA;
            ST_UPD_DATA: next_state = tms ? ST_SEL_DATA : ST_IDLE;
            ST_SEL_INSTR: next_state = tms ? ST_TLR : ST_CAP_INSTR;
            ST_CAP_INSTR: next_state = tms ? ST_EX1_INSTR : ST_SH_INSTR;
            ST_SH_INSTR: next_state = tms ? ST_EX1_INSTR : ST_SH_INSTR;
            ST_EX1_INSTR: next_state = tms ? ST_UPD_INSTR : ST_PAUSE_INSTR;
            ST_PAUSE_INSTR: next_state = tms ? ST_EX2_INSTR : ST_PAUSE_INSTR;
            ST_EX2_INSTR: next_state = tms ? ST_UPD_INSTR : ST_SH_INSTR;
            ST_UPD_INSTR: next_state = tms ? ST_SEL_DATA : ST_IDLE;
            default: next_state = ST_TLR;
        endcase
    end

    // Five edges with mode select high reach test-logic reset from any state.
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            state <= ST_TLR;
        end else begin
            state <= next_state;
        end
    end

    a_five_ones_reset: assert property (@(posedge tck) disable iff (rst)
        tms [*5] |-> ##1 (state == ST_TLR))
        else $error("five high mode-select edges did not reach test-logic reset");
endmodule : tap_fsm
`default_nettype wire

/* dv/jtag_tester.sv */
// Behavioural test port driver that steers the controller and shifts registers.
`default_nettype none
module jtag_tester (
    // Test port
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // The test clock stands still between calls, so the link is quiet outside frames.
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #80;
        q = tdo;
        tck = 1'b1;
        #80;
        tck = 1'b0;
    endtask : step
    // Outside shifting the data line toggles, so a design must not rely on its last value.
    task automatic scan(input logic ir, input logic [133:0] din, input int n,
            output logic [133:0] dout);
        logic q;
        dout = '0;
        step(1'b1, ~tdi, q);
        if (ir) step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
        step(1'b0, ~tdi, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
    endtask : scan
endmodule : jtag_tester
`default_nettype wire

/* dv/tb.sv */
// Self-checking bench for instruction decode, identification, bypass, flash and boundary scans.
`default_nettype none
`include "jtag_tap_map.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    // Identification value is arbitrary.
    localparam logic [31:0] ID = 32'h0c3c_7001;
    logic clk, rst, tck, tms, tdi, tdo, tdo_en_n, rst_pin_in, rst_pin_out, rst_pin_oe_n;
    logic crystal_input_pin, pullup_en, core_rst_drive, core_rst_out, core_rst_in, core_pullup_en;
    logic [63:0] pin_in, pin_out, pin_oe_n, core_out, core_oe, core_in;
    logic [7:0] fctl, fscl;
    logic [9:0] fdat;
    logic [16:0] fadr;
    logic [133:0] cap;
    int err_total, compares;
    jtag_tap_boundary_scan #(.LARGE_PACKAGE(1'b1), .ID_CODE(ID)) jtag_tap_boundary_scan_i (
        .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_en_n(tdo_en_n),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .rst_pin_in(rst_pin_in),
        .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n), .pullup_en(pullup_en),
        .crystal_input_pin(crystal_input_pin), .core_out(core_out), .core_oe(core_oe),
        .core_in(core_in), .core_rst_drive(core_rst_drive), .core_rst_out(core_rst_out),
        .core_rst_in(core_rst_in), .core_pullup_en(core_pullup_en), .flash_control_reg(fctl),
        .flash_data_reg(fdat), .flash_address_reg(fadr), .flash_timing_scale_reg(fscl));
    jtag_tester jtag_tester_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [133:0] got, input logic [133:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [133:0] pack(input logic [5:0] lo, input logic [63:0] ev,
            input logic [63:0] od);
        pack[5:0] = lo;
        for (int i = 0; i < 64; i++) {pack[7 + 2 * i], pack[6 + 2 * i]} = {od[i], ev[i]};
    endfunction : pack
    task automatic load_ir(input logic [15:0] code);
        jtag_tester_i.scan(1'b1, 134'(code), 16, cap);
        chk(134'(cap[15:0]), 134'(`INSTR_CAPTURE));
        chk(134'(tdo_en_n), 134'h1);
    endtask : load_ir
    task automatic wclk();
        repeat (10) @(posedge clk);
        #1;
    endtask : wclk
    task automatic end_sim();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic t_id_bypass();
        logic [15:0] codes [2] = '{`BYPASS_CODE, 16'h1234};
        load_ir(`IDCODE_CODE);
        jtag_tester_i.scan(1'b0, '0, 32, cap);
        chk(134'(cap[31:0]), 134'(ID));
        foreach (codes[k]) begin
            load_ir(codes[k]);
            jtag_tester_i.scan(1'b0, 134'h5, 4, cap);
            chk(134'(cap[3:0]), 134'ha);
        end
    endtask : t_id_bypass
    task automatic t_flash();
        logic [19:0] v [4] = '{20'h3c5a7, 20'h8e2d9, 20'h1b6f4, 20'hd7c3e};
        for (int k = 0; k < 4; k++) begin
            load_ir(`FLASH_CTL_CODE + 16'(k));
            jtag_tester_i.scan(1'b0, 134'(v[k]), 20, cap);
        end
        chk(134'(fctl), 134'(v[0][7:0]));
        chk(134'(fdat), 134'(v[1][9:0]));
        chk(134'(fadr), 134'(v[2][16:0]));
        chk(134'(fscl), 134'(v[3][7:0]));
    endtask : t_flash
    task automatic t_boundary();
        logic [133:0] e;
        e = pack({core_pullup_en, crystal_input_pin, rst_pin_in, core_rst_drive, 2'b00},
            core_oe, pin_in);
        load_ir(`EXTEST_CODE);
        jtag_tester_i.scan(1'b0, pack(6'h2c, 64'h00ff_0f0f_3333_5555, 64'h1234), 134, cap);
        chk(cap, e);
        wclk();
        chk({pin_out, pin_oe_n}, {64'h1234, ~64'h00ff_0f0f_3333_5555});
        chk({core_in, core_rst_in, rst_pin_out, rst_pin_oe_n, pullup_en}, {64'hffff_ffff_ffff_ffff, 4'hd});
        load_ir(`INSTR_A_CODE);
        jtag_tester_i.scan(1'b0, pack(6'h04, 64'hffff_0000, 64'h2468_ace0), 134, cap);
        chk(cap, e);
        wclk();
        chk({pin_out, pin_oe_n, core_in}, {core_out, ~core_oe, pin_in});
        chk({rst_pin_out, rst_pin_oe_n, pullup_en}, {core_rst_out, ~core_rst_drive, core_pullup_en});
        load_ir(`EXTEST_CODE);
        wclk();
        chk({pin_out, pin_oe_n, rst_pin_oe_n}, {64'h2468_ace0, ~64'hffff_0000, 1'b0});
    endtask : t_boundary
    initial begin
        err_total = 0;
        compares = 0;
        rst = 1'b1;
        pin_in = 64'h0123_4567_89ab_cdef;
        core_oe = 64'hc3c3_a5a5_0ff0_6996;
        core_out = 64'h9696_3c3c_f00f_5aa5;
        {rst_pin_in, core_rst_drive, core_rst_out, crystal_input_pin, core_pullup_en} = 5'h1a;
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        jtag_tester_i.step(1'b0, 1'b0, cap[0]);
        t_id_bypass();
        t_flash();
        t_boundary();
        end_sim();
    end
    initial begin
        #2000000;
        err_total++;
        end_sim();
    end
endmodule : tb
`default_nettype wire
